// file: verilog/psi_pkg.sv
// Package of constants and types for the program counter, stack and indirect addressing block.
package psi_pkg;
	localparam int PC_W      = 13;
	localparam int BYTE_W    = 8;
	localparam int HI_W      = 5;
	localparam int STK_DEPTH = 8;
	localparam int SP_W      = 3;
	localparam int JMP_W     = 11;
	localparam int FADDR_W   = 9;

	localparam logic [PC_W-1:0]    PC_RESET   = 13'h0000;
	localparam logic [PC_W-1:0]    PC_ONE     = 13'h0001;
	localparam logic [SP_W-1:0]    SP_RESET   = 3'h0;
	localparam logic [SP_W-1:0]    SP_ONE     = 3'h1;
	localparam logic [BYTE_W-1:0]  BYTE_ZERO  = 8'h00;
	localparam logic [BYTE_W-1:0]  LATCH_RST  = 8'h00;
	localparam logic [PC_W-1:0]    INT_VECTOR = 13'h0004;
	// Register file address of the indirect window within a bank.
	localparam logic [BYTE_W-1:0]  WINDOW_ADDR = 8'h00;

	typedef enum logic [2:0] {
		PSI_OP_NEXT,
		PSI_OP_HOLD,
		PSI_OP_JUMP,
		PSI_OP_CALL,
		PSI_OP_RET,
		PSI_OP_INT
	} psi_op_t;

	// Control request from the execution logic for one instruction step.
	typedef struct packed {
		logic                 step;
		psi_op_t              op;
		logic [JMP_W-1:0]     target;
	} psi_flow_t;

	// Data-space access request for the register file.
	typedef struct packed {
		logic                 rd;
		logic                 wr;
		logic [BYTE_W-1:0]    addr;
		logic [BYTE_W-1:0]    wdata;
		logic                 bank_bit;
	} psi_dreq_t;

	// Resolved data-space access toward the register file.
	typedef struct packed {
		logic                 rd;
		logic                 wr;
		logic [FADDR_W-1:0]   addr;
		logic [BYTE_W-1:0]    wdata;
		logic                 force_zero;
	} psi_dacc_t;
endpackage

// file: verilog/psi_stack_mem.sv
// Eight-entry return address memory with a registered read port.
`timescale 1ns/1ps
module psi_stack_mem (
	// Clock and reset
	input  wire logic                        i_mclk,
	input  wire logic                        i_sys_rst,
	// Write port
	input  wire logic                        i_we,
	input  wire logic [psi_pkg::SP_W-1:0]    i_waddr,
	input  wire logic [psi_pkg::PC_W-1:0]    i_wdata,
	// Read port
	input  wire logic [psi_pkg::SP_W-1:0]    i_raddr,
	output logic      [psi_pkg::PC_W-1:0]    o_rdata
);
	import psi_pkg::*;

	logic [PC_W-1:0] mem_q [STK_DEPTH];

	// ==========================================================
	// Storage
	genvar g;
	generate
		for (g = 0; g < STK_DEPTH; g++) begin : g_ent
			always_ff @(posedge i_mclk) begin
				if (i_sys_rst) begin
					mem_q[g] <= PC_RESET;
				end else if (i_we && (i_waddr == SP_W'(g))) begin
					mem_q[g] <= i_wdata;
				end
			end
		end
	endgenerate

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_rdata <= PC_RESET;
		end else begin
			o_rdata <= mem_q[i_raddr];
		end
	end
endmodule

// file: verilog/psi_core.sv
// Program counter, circular return stack and indirect address former.
// Operation
// - 13-bit PC: low byte, upper from latch
// - Any reset clears the program counter
// - Low-byte write loads PC[12:8] from latch
// - Call/jump takes latch bits 4:3 on top
// - Eight 13-bit entries, pointer hidden from software
// - Push on call/interrupt, pop on returns
// - Push and pop leave latch unchanged
// - Stack wraps circularly, ninth overwrites first
// - No overflow or underflow indication at all
// - Window access redirects to pointer location
// - Window reading itself returns zero
// - Window writing itself stores nothing
// - Indirect address is bank bit over pointer
`timescale 1ns/1ps
module psi_core (
	// Clock and reset
	input  wire logic                        i_mclk,
	input  wire logic                        i_sys_rst,
	// Instruction flow
	input  wire psi_pkg::psi_flow_t          i_flow,
	// Low-byte write and high latch write
	input  wire logic                        i_pcl_wr,
	input  wire logic [psi_pkg::BYTE_W-1:0]  i_pcl_wdata,
	input  wire logic                        i_latch_wr,
	input  wire logic [psi_pkg::BYTE_W-1:0]  i_latch_wdata,
	// Pointer register write
	input  wire logic                        i_ptr_wr,
	input  wire logic [psi_pkg::BYTE_W-1:0]  i_ptr_wdata,
	// Data access from execution logic
	input  wire psi_pkg::psi_dreq_t          i_dreq,
	// Program counter state and pointer register
	output logic      [psi_pkg::PC_W-1:0]    o_pc,
	output logic      [psi_pkg::BYTE_W-1:0]  o_pc_low_byte,
	output logic      [psi_pkg::BYTE_W-1:0]  o_pc_high_latch,
	output logic      [psi_pkg::BYTE_W-1:0]  o_pointer_register,
	// Resolved data access
	output psi_pkg::psi_dacc_t               o_dacc
);
	import psi_pkg::*;

	logic [PC_W-1:0]   pc_q;
	logic [PC_W-1:0]   pc_d;
	logic [BYTE_W-1:0] latch_q;
	logic [BYTE_W-1:0] ptr_q;
	logic [SP_W-1:0]   sp_q;
	logic [SP_W-1:0]   sp_d;
	logic              pop_pend_q;
	logic [PC_W-1:0]   stk_rdata;
	psi_dacc_t         dacc_q;

	// ==========================================================
	// Decode of the instruction step
	wire is_step    = i_flow.step;
	wire do_call    = is_step && (i_flow.op == PSI_OP_CALL);
	wire do_int     = is_step && (i_flow.op == PSI_OP_INT);
	wire do_jump    = is_step && (i_flow.op == PSI_OP_JUMP);
	wire do_ret     = is_step && (i_flow.op == PSI_OP_RET);
	wire do_next    = is_step && (i_flow.op == PSI_OP_NEXT);
	wire do_push    = do_call || do_int;
	// The returned address is read from the entry below the pointer.
	wire [SP_W-1:0] sp_top  = sp_q - SP_ONE;
	wire [PC_W-1:0] pc_inc  = pc_q + PC_ONE;
	// Call and jump place latch bits 4:3 above the 11-bit target.
	wire [PC_W-1:0] pc_far  = {latch_q[HI_W-1:HI_W-2], i_flow.target};
	// A low-byte write takes all five latch bits as the upper part.
	wire [PC_W-1:0] pc_lwr  = {latch_q[HI_W-1:0], i_pcl_wdata};

	// ==========================================================
	// Next program counter
	always_comb begin
		pc_d = pc_q;
		if (i_pcl_wr) begin
			pc_d = pc_lwr;
		end else if (do_call || do_jump) begin
			pc_d = pc_far;
		end else if (do_int) begin
			pc_d = INT_VECTOR;
		end else if (do_next) begin
			pc_d = pc_inc;
		end
	end

	// Pointer moves freely and wraps with no flag of any kind.
	always_comb begin
		sp_d = sp_q;
		if (do_push) begin
			sp_d = sp_q + SP_ONE;
		end else if (do_ret) begin
			sp_d = sp_top;
		end
	end

	// ==========================================================
	// Stack storage; the pushed value is the return address.
	// The read port always looks at the entry just below the pointer. A return step
	// therefore finds the address it needs already selected, and the registered read
	// hands it over one cycle later.
	psi_stack_mem u_stack (
		.i_mclk    (i_mclk),
		.i_sys_rst (i_sys_rst),
		.i_we      (do_push),
		.i_waddr   (sp_q),
		.i_wdata   (do_call ? pc_inc : pc_q),
		.i_raddr   (sp_top),
		.o_rdata   (stk_rdata)
	);

	// ==========================================================
	// Indirect addressing
	wire win_hit   = (i_dreq.addr == WINDOW_ADDR);
	wire self_ref  = win_hit && (ptr_q == WINDOW_ADDR);
	wire [FADDR_W-1:0] ind_addr = {i_dreq.bank_bit, ptr_q};
	wire [FADDR_W-1:0] dir_addr = {i_dreq.bank_bit, i_dreq.addr};
	psi_dacc_t dacc_d;
	always_comb begin
		dacc_d.addr       = win_hit ? ind_addr : dir_addr;
		dacc_d.rd         = i_dreq.rd && !self_ref;
		dacc_d.wr         = i_dreq.wr && !self_ref;
		dacc_d.wdata      = i_dreq.wdata;
		dacc_d.force_zero = i_dreq.rd && self_ref;
	end

	// ==========================================================
	// State registers
	// A return needs the registered stack read, so the popped address lands one cycle
	// after the return step. The working counter takes it as well as the visible copy,
	// so the next sequential step counts on from the return address.
	wire [PC_W-1:0] pc_nx = pop_pend_q ? stk_rdata : pc_d;

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			pc_q <= PC_RESET;
		end else begin
			pc_q <= pc_nx;
		end
	end

	// The stack pointer is internal only; no port shows it.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			sp_q <= SP_RESET;
		end else begin
			sp_q <= sp_d;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			pop_pend_q <= 1'b0;
		end else begin
			pop_pend_q <= do_ret;
		end
	end

	// ==========================================================
	// Software-visible state
	// The latch only changes by software writes, never by stack traffic.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			latch_q <= LATCH_RST;
		end else if (i_latch_wr) begin
			latch_q <= i_latch_wdata;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			ptr_q <= BYTE_ZERO;
		end else if (i_ptr_wr) begin
			ptr_q <= i_ptr_wdata;
		end
	end

	// ==========================================================
	// Output registers
	// Each output but o_dacc is its own flip-flop that mirrors the state it reports; o_dacc is the dacc_q register itself.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_pc <= PC_RESET;
		end else begin
			o_pc <= pc_nx;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_pc_low_byte <= BYTE_ZERO;
		end else begin
			o_pc_low_byte <= pc_nx[BYTE_W-1:0];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_pc_high_latch <= LATCH_RST;
		end else begin
			o_pc_high_latch <= i_latch_wr ? i_latch_wdata : latch_q;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_pointer_register <= BYTE_ZERO;
		end else begin
			o_pointer_register <= i_ptr_wr ? i_ptr_wdata : ptr_q;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			dacc_q <= '0;
		end else begin
			dacc_q <= dacc_d;
		end
	end

	assign o_dacc = dacc_q;
endmodule

// file: testbench/psi_core_assertions.sv
// Assertion checker for the program counter, stack and indirect address former.
`timescale 1ns/1ps
module psi_core_assertions (
	// Clock, reset and requests
	input wire logic		i_mclk,
	input wire logic		i_sys_rst,
	input wire psi_pkg::psi_flow_t	i_flow,
	input wire logic		i_pcl_wr,
	input wire logic [7:0]		i_pcl_wdata,
	input wire logic		i_latch_wr,
	input wire logic		i_ptr_wr,
	input wire psi_pkg::psi_dreq_t	i_dreq,
	// Design outputs
	input wire logic [12:0]		o_pc,
	input wire logic [7:0]		o_pc_high_latch,
	input wire logic [7:0]		o_pointer_register,
	input wire psi_pkg::psi_dacc_t	o_dacc
);
	import psi_pkg::*;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	wire q = !i_pcl_wr && !i_latch_wr;
	wire win = i_dreq.addr == WINDOW_ADDR && (i_dreq.rd || i_dreq.wr) && !i_ptr_wr;
	wire me = o_pointer_register == WINDOW_ADDR;
	wire ld = i_flow.step && q && (i_flow.op == PSI_OP_CALL || i_flow.op == PSI_OP_JUMP);
	wire [4:0] hi5 = o_pc_high_latch[4:0];
	wire [1:0] hi2 = o_pc_high_latch[4:3];
	wire [10:0] tgt = i_flow.target;
	wire bnk = i_dreq.bank_bit;
	wire rdq = i_dreq.rd;
	AST_RESET_PC: assert property ($fell(i_sys_rst) |-> o_pc == PC_RESET)
		else $error("pc not cleared");
	AST_PCL_LOAD: assert property (i_pcl_wr && !i_latch_wr |=> o_pc == {$past(hi5), $past(i_pcl_wdata)})
		else $error("low byte load");
	AST_CALL_JUMP: assert property (ld |=> o_pc == {$past(hi2), $past(tgt)})
		else $error("call or jump load");
	AST_NEXT: assert property (i_flow.step && q && i_flow.op == PSI_OP_NEXT |=> o_pc == $past(o_pc) + PC_ONE)
		else $error("sequential step");
	AST_INT: assert property (i_flow.step && q && i_flow.op == PSI_OP_INT |=> o_pc == INT_VECTOR)
		else $error("interrupt vector");
	AST_LATCH_KEEP: assert property (!i_latch_wr |=> $stable(o_pc_high_latch))
		else $error("latch changed");
	AST_WIN_ADDR: assert property (win && !me |=> o_dacc.addr == {$past(bnk), $past(o_pointer_register)})
		else $error("indirect address");
	AST_WIN_SELF: assert property (win && me |=> !o_dacc.wr && !o_dacc.rd && o_dacc.force_zero == $past(rdq))
		else $error("window self access");
	cover property (ld);
	cover property (i_flow.step && i_flow.op == PSI_OP_RET);
	cover property (win && me && rdq);
endmodule
bind psi_core psi_core_assertions i_chk (.i_mclk, .i_sys_rst, .i_flow, .i_pcl_wr, .i_pcl_wdata,
	.i_latch_wr, .i_ptr_wr, .i_dreq, .o_pc, .o_pc_high_latch, .o_pointer_register, .o_dacc);

// file: testbench/tb.sv
// Self-checking bench for the program counter, stack and indirect address former.
`timescale 1ns/1ps
module tb;
	import psi_pkg::*;
	typedef struct packed {
		logic [7:0] ptr;
		logic [2:0] req;
		logic [11:0] exp;
	} psi_row_t;
	logic i_mclk = 1'b0;
	logic i_sys_rst = 1'b1;
	psi_flow_t flow = '0;
	psi_dreq_t dreq = '0;
	logic [7:0] wd = 8'h00;
	logic [2:0] wen = 3'h0;
	logic [12:0] o_pc, pc_m, stk [8];
	logic [7:0] o_low, o_lat, o_ptr;
	logic [7:0] lat_m = 8'h00;
	logic [2:0] sp = 3'h0;
	psi_dacc_t dacc;
	int n_mismatch = 0;
	int compares = 0;
	// Row: pointer, {bank, rd, wr}, expected {rd, wr, force_zero, address}.
	psi_row_t rows [5] = '{'{8'h20, 3'h2, 12'h8_20}, '{8'hFF, 3'h5, 12'h5_FF},
		'{8'h80, 3'h6, 12'h9_80}, '{8'h00, 3'h2, 12'h2_00}, '{8'h00, 3'h5, 12'h1_00}};
	always #2.5 i_mclk = ~i_mclk;
	psi_core i_dut (.i_mclk, .i_sys_rst, .i_flow(flow), .i_pcl_wr(wen[1]), .i_pcl_wdata(wd),
		.i_latch_wr(wen[0]), .i_latch_wdata(wd), .i_ptr_wr(wen[2]), .i_ptr_wdata(wd),
		.i_dreq(dreq), .o_pc, .o_pc_low_byte(o_low), .o_pc_high_latch(o_lat),
		.o_pointer_register(o_ptr), .o_dacc(dacc));
	task chk(input string n, input logic [12:0] e, input logic [12:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task test_done;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Write strobe bit 0 is the latch, bit 1 the low byte, bit 2 the pointer.
	task wr(input logic [2:0] k, input logic [7:0] d);
		@(posedge i_mclk);
		wen <= k;
		wd <= d;
		@(posedge i_mclk);
		wen <= 3'h0;
		#1;
	endtask
	task op(input psi_op_t o, input logic [10:0] t);
		@(posedge i_mclk);
		flow <= '{1'b1, o, t};
		@(posedge i_mclk);
		flow <= '0;
		if (o == PSI_OP_RET)
			@(posedge i_mclk);
		#1;
		case (o)
			PSI_OP_NEXT: pc_m = pc_m + PC_ONE;
			PSI_OP_HOLD: pc_m = pc_m;
			PSI_OP_JUMP: pc_m = {lat_m[4:3], t};
			PSI_OP_RET: begin
				sp = sp - SP_ONE;
				pc_m = stk[sp];
			end
			default: begin
				stk[sp] = (o == PSI_OP_CALL) ? pc_m + PC_ONE : pc_m;
				sp = sp + SP_ONE;
				pc_m = (o == PSI_OP_CALL) ? {lat_m[4:3], t} : INT_VECTOR;
			end
		endcase
		chk("pc", pc_m, o_pc);
		chk("latch", 13'(lat_m), 13'(o_lat));
	endtask
	initial begin
		repeat (4) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		#1;
		chk("reset pc", PC_RESET, o_pc);
		foreach (rows[i]) begin
			wr(3'h4, rows[i].ptr);
			@(posedge i_mclk);
			dreq <= '{rows[i].req[1], rows[i].req[0], WINDOW_ADDR, 8'h5A, rows[i].req[2]};
			@(posedge i_mclk);
			dreq <= '0;
			#1;
			chk("dacc", 13'(rows[i].exp), 13'({dacc.rd, dacc.wr, dacc.force_zero,
				dacc.addr}));
			chk("wdata", 13'h005A, 13'(dacc.wdata));
			chk("pointer", 13'(rows[i].ptr), 13'(o_ptr));
		end
		wr(3'h1, 8'h02);
		wr(3'h2, 8'hFF);
		chk("pc", 13'h02FF, o_pc);
		wr(3'h2, 8'h00);
		chk("pc", 13'h0200, o_pc);
		chk("latch", 13'h0002, 13'(o_lat));
		wr(3'h1, 8'h03);
		wr(3'h2, 8'h00);
		chk("pc", 13'h0300, o_pc);
		wr(3'h1, 8'h1F);
		lat_m = 8'h1F;
		wr(3'h2, 8'hFE);
		pc_m = 13'h1FFE;
		chk("pc", pc_m, o_pc);
		chk("low byte", 13'h00FE, 13'(o_low));
		op(PSI_OP_NEXT, 11'h000);
		op(PSI_OP_NEXT, 11'h000);
		op(PSI_OP_HOLD, 11'h000);
		wr(3'h1, 8'h08);
		lat_m = 8'h08;
		op(PSI_OP_JUMP, 11'h7FF);
		wr(3'h1, 8'h18);
		lat_m = 8'h18;
		for (int i = 0; i < 9; i++)
			op(PSI_OP_CALL, 11'(i * 5 + 1));
		op(PSI_OP_INT, 11'h000);
		for (int i = 0; i < 8; i++)
			op(PSI_OP_RET, 11'h000);
		op(PSI_OP_NEXT, 11'h000);
		@(posedge i_mclk);
		i_sys_rst <= 1'b1;
		@(posedge i_mclk);
		i_sys_rst <= 1'b0;
		#1;
		chk("reset pc", PC_RESET, o_pc);
		chk("reset low byte", 13'h0000, 13'(o_low));
		chk("reset latch", 13'h0000, 13'(o_lat));
		test_done;
	end
endmodule
